// File: logic/loopback_cfg.svh
// constants for the traffic channel test loopback
`ifndef LOOPBACK_CFG_SVH
`define LOOPBACK_CFG_SVH
// ----------------------------------------
// frame widths and control link service point
// ----------------------------------------
`define FR_BITS      9'h104
`define EFR_BITS     9'h0F4
`define HR_BITS      9'h070
`define MAX_BITS     260
`define FILL_BITS    35
`define CTL_LINK_SERVICE_POINT     3'h0
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define OFF_CTRL     12'h000
`define OFF_STATUS   12'h004
`define OFF_LOOPED   12'h008
`define OFF_ZEROED   12'h00C
`define CTRL_DEACT   0
`define CTRL_AUDIO   1
`define CTRL_ACS_LO  2
`define CTRL_ACS_HI  4
`define ACS_RESET    3'h1
`endif

// File: logic/loopback_pkg.sv
// types of the traffic channel test loopback
package loopback_pkg;
  typedef enum logic [2:0] {
    CH_FULL, CH_ENH, CH_HALF, CH_AFULL, CH_AHALF, CH_WFULL, CH_OWFULL, CH_OWHALF
  } chanKind_t;

  typedef enum logic [3:0] {
    RX_SPEECH, RX_BAD, RX_USER, RX_STEAL, RX_REFRESH, RX_START, RX_START_ONE,
    RX_START_TWO, RX_INH_START, RX_INH_REFRESH, RX_ONSET, RX_NODATA,
    RX_ROBUST, RX_MARKER, RX_PAYLOAD
  } rxType_t;

  typedef struct packed {
    logic         valid;
    rxType_t      rxType;
    logic         badFrameFlag;
    logic [1:0]   mode;
    logic [8:0]   width;
    logic [259:0] data;
  } dlFrame_t;

  typedef struct packed {
    logic         valid;
    logic [259:0] data;
    logic [8:0]   width;
    logic [1:0]   modeInd;
    logic [1:0]   modeReq;
    logic         goodClass;
  } ulFrame_t;

  typedef struct packed {
    logic         valid;
    chanKind_t    chan;
    logic [2:0]   link_service_point;
    logic         ackMode;
  } order_t;

  typedef struct packed {
    logic         loopClosed;
    logic         audioTest;
    chanKind_t    chan;
    logic [2:0]   acsCount;
    logic [1:0]   modeCmd;
    logic [1:0]   prevMode;
    logic [8:0]   prevWidth;
    logic         pendZero;
    logic         pendData;
    logic [34:0]  pendBits;
    logic         dlReady;
    ulFrame_t     ul;
    logic         confirm;
    logic         robustEn;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic [15:0]  looped;
    logic [15:0]  zeroed;
    logic         remSync1;
    logic         remSync2;
  } state_t;
endpackage

// File: logic/voice_loopback.sv
// traffic channel test loopback with apb control
`timescale 1ns/100ps
`default_nettype none
`include "loopback_cfg.svh"

// Contract
// - loop close orders are taken only from control path, service point zero, acknowledged
// - deactivate on deactivation command, power off or subscriber module removal
// - traffic loop and digital audio test never active together
// - ignore close order if no traffic channel active or a loop already closed
// - otherwise close loop on the named channel and return a confirmation
// - closed loop passes good voice and user data frames uplink
// - fixed widths 260 full, 112 half, 244 enhanced
// - adaptive width equals decoded mode payload, decoder data fed directly
// - bad voice frame becomes all-zero uplink frame
// - non-adaptive signalling steal gives no uplink frame, signalling keeps going
// - with several codec modes ignore mode commands, use looped frame mode
// - no mode requests; indication and request carry looped frame mode
// - empty, robust, noise start and refresh frames reuse previous uplink mode
// - adaptive uplink frames always carry good voice class
// - valid noise refresh: first 35 bits, rest zero
// - half rate noise refresh gives zero frame then parameter frame
// - erased noise refresh gives zero frame, two on half rate
// - closed loop disables robust signalling and its acknowledgment
// - valid robust frame first 35 bits; half rate marker zero, then data
// - erased robust frame gives zero frame, two on half rate; code gives two on CH_AHALF only, one on CH_OWHALF
// - onset, start, empty, inhibited frames become all-zero frames
module voice_loopback
  import loopback_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire order_t      order,
  input  wire logic        openOrder,
  input  wire logic        powerOff,
  input  wire logic        moduleRemovedPin,
  input  wire logic        trafficActive,
  input  wire logic        modeCmdValid,
  input  wire logic [1:0]  modeCmd,
  input  wire dlFrame_t    dl,
  output logic             dlReady,
  output ulFrame_t         ul,
  output logic             loopCloseConfirm,
  output logic             loopClosed,
  output logic             audioTestActive,
  output logic             robustSignallingEnable
);
  state_t s_q;
  state_t s_d;
  logic   orderOk;
  logic   deact;
  logic   adaptive;
  logic   halfAdp;
  logic   reuseMode;
  logic   take;
  logic   apbDone;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.remSync1 = moduleRemovedPin;
    s_d.remSync2 = s_q.remSync1;
    s_d.confirm = 1'b0;
    s_d.ul.valid = 1'b0;
    adaptive = (s_q.chan >= CH_AFULL);
    halfAdp = (s_q.chan == CH_AHALF) || (s_q.chan == CH_OWHALF);
    apbDone = psel && penable && !s_q.pready;
    deact = openOrder || powerOff || s_q.remSync2 ||
            (apbDone && pwrite && paddr == `OFF_CTRL && pwdata[`CTRL_DEACT]);
    orderOk = order.valid && order.link_service_point == `CTL_LINK_SERVICE_POINT && order.ackMode &&
              trafficActive && !s_q.loopClosed && !s_q.audioTest;
    take = s_q.loopClosed && dl.valid && s_q.dlReady;
    reuseMode = 1'b0;
    // mode commands only steer a single-mode set
    if (modeCmdValid && s_q.acsCount <= 3'h1) begin
      s_d.modeCmd = modeCmd;
    end
    // ----------------------------------------
    // loop control
    // ----------------------------------------
    if (deact) begin
      s_d.loopClosed = 1'b0;
      s_d.audioTest = 1'b0;
      s_d.pendZero = 1'b0;
      s_d.pendData = 1'b0;
    end else if (orderOk) begin
      s_d.loopClosed = 1'b1;
      s_d.chan = order.chan;
      s_d.confirm = 1'b1;
    end
    s_d.robustEn = !s_d.loopClosed;
    // ----------------------------------------
    // frame path
    // ----------------------------------------
    if (s_q.loopClosed && !deact && (s_q.pendZero || s_q.pendData)) begin
      s_d.ul.valid = 1'b1;
      s_d.ul.data = '0;
      if (s_q.pendData) begin
        s_d.ul.data[`FILL_BITS-1:0] = s_q.pendBits;
      end
      s_d.pendZero = 1'b0;
      s_d.pendData = 1'b0;
    end else if (take && !deact) begin
      s_d.ul.valid = 1'b1;
      s_d.ul.data = '0;
      s_d.ul.goodClass = 1'b1;
      case (dl.rxType)
        RX_SPEECH, RX_USER, RX_ONSET: reuseMode = 1'b0;
        RX_BAD: reuseMode = 1'b0;
        default: reuseMode = adaptive;
      endcase
      if (!adaptive) begin
        case (s_q.chan)
          CH_ENH: s_d.ul.width = `EFR_BITS;
          CH_HALF: s_d.ul.width = `HR_BITS;
          default: s_d.ul.width = `FR_BITS;
        endcase
      end else if (reuseMode) begin
        s_d.ul.width = s_q.prevWidth;
      end else begin
        s_d.ul.width = dl.width;
      end
      if (reuseMode) begin
        s_d.ul.modeInd = s_q.prevMode;
      end else if (s_q.acsCount > 3'h1) begin
        s_d.ul.modeInd = dl.mode;
      end else begin
        s_d.ul.modeInd = s_q.modeCmd;
      end
      s_d.ul.modeReq = s_d.ul.modeInd;
      case (dl.rxType)
        RX_SPEECH, RX_USER: begin
          for (int i = 0; i < `MAX_BITS; i++) begin
            s_d.ul.data[i] = dl.data[i] && (i < int'(s_d.ul.width));
          end
        end
        RX_STEAL: s_d.ul.valid = adaptive;
        RX_REFRESH, RX_ROBUST: begin
          if (dl.badFrameFlag && dl.rxType == RX_REFRESH) begin
            s_d.pendZero = halfAdp;
          end else if (dl.badFrameFlag) begin
            s_d.pendZero = (s_q.chan == CH_AHALF);
          end else if (halfAdp && dl.rxType == RX_REFRESH) begin
            s_d.pendData = 1'b1;
            s_d.pendBits = dl.data[`FILL_BITS-1:0];
          end else begin
            s_d.ul.data[`FILL_BITS-1:0] = dl.data[`FILL_BITS-1:0];
          end
        end
        RX_PAYLOAD: begin
          if (!dl.badFrameFlag) begin
            s_d.ul.data[`FILL_BITS-1:0] = dl.data[`FILL_BITS-1:0];
          end
        end
        RX_BAD: s_d.ul.data = '0;
        default: s_d.ul.data = '0;
      endcase
    end
    if (s_d.ul.valid) begin
      s_d.prevMode = s_d.ul.modeInd;
      s_d.prevWidth = s_d.ul.width;
      if (s_d.ul.data == '0) begin
        s_d.zeroed = s_q.zeroed + 16'h0001;
      end else begin
        s_d.looped = s_q.looped + 16'h0001;
      end
    end
    s_d.dlReady = !(s_d.pendZero || s_d.pendData);
    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    s_d.pready = apbDone;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h0000_0000;
    if (apbDone) begin
      case (paddr)
        `OFF_CTRL: begin
          if (pwrite) begin
            s_d.acsCount = pwdata[`CTRL_ACS_HI:`CTRL_ACS_LO];
            if (!pwdata[`CTRL_AUDIO] || deact) begin
              s_d.audioTest = 1'b0;
            end else if (!s_q.loopClosed && !orderOk) begin
              s_d.audioTest = 1'b1;
            end
          end
          s_d.prdata = {27'h0, s_q.acsCount, s_q.audioTest, 1'b0};
        end
        `OFF_STATUS: s_d.prdata = {24'h0, s_q.robustEn, s_q.prevMode, s_q.chan,
                                   s_q.audioTest, s_q.loopClosed};
        `OFF_LOOPED: s_d.prdata = {16'h0, s_q.looped};
        `OFF_ZEROED: s_d.prdata = {16'h0, s_q.zeroed};
        default: s_d.pslverr = 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.acsCount <= `ACS_RESET;
      s_q.robustEn <= 1'b1;
      s_q.dlReady <= 1'b1;
      s_q.chan <= CH_FULL;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign dlReady = s_q.dlReady;
  assign ul = s_q.ul;
  assign loopCloseConfirm = s_q.confirm;
  assign loopClosed = s_q.loopClosed;
  assign audioTestActive = s_q.audioTest;
  assign robustSignallingEnable = s_q.robustEn;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_confirmCause;
    @(posedge clk) disable iff (!nrst)
    loopCloseConfirm |-> $past(order.valid) && $past(order.link_service_point) == 3'h0 && $past(trafficActive);
  endproperty
  a_confirmCause: assert property (p_confirmCause)
    else $error("confirm without a valid order");

  property p_ignoreClosed;
    @(posedge clk) disable iff (!nrst)
    loopClosed && order.valid |=> !loopCloseConfirm;
  endproperty
  a_ignoreClosed: assert property (p_ignoreClosed)
    else $error("order taken while loop closed");

  property p_closeConfirm;
    @(posedge clk) disable iff (!nrst)
    orderOk && !deact |=> loopClosed && loopCloseConfirm;
  endproperty
  a_closeConfirm: assert property (p_closeConfirm)
    else $error("accepted order did not close loop");

  property p_exclusive;
    @(posedge clk) disable iff (!nrst)
    !(loopClosed && audioTestActive);
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("loop and audio test both active");

  property p_powerOff;
    @(posedge clk) disable iff (!nrst)
    powerOff |=> !loopClosed ##1 !loopClosed || $past(orderOk);
  endproperty
  a_powerOff: assert property (p_powerOff)
    else $error("power off did not open loop");

  property p_badZero;
    @(posedge clk) disable iff (!nrst)
    take && !deact && dl.rxType == RX_BAD |=> ul.valid && ul.data == '0 && ul.goodClass;
  endproperty
  a_badZero: assert property (p_badZero)
    else $error("bad frame not zeroed");

  property p_halfWidth;
    @(posedge clk) disable iff (!nrst)
    take && s_q.chan == CH_HALF && dl.rxType == RX_SPEECH |=> ul.width == 9'h070;
  endproperty
  a_halfWidth: assert property (p_halfWidth)
    else $error("half rate width wrong");

  property p_modeReq;
    @(posedge clk) disable iff (!nrst)
    ul.valid |-> ul.modeReq == ul.modeInd;
  endproperty
  a_modeReq: assert property (p_modeReq)
    else $error("mode request differs from indication");

  property p_robustOff;
    @(posedge clk) disable iff (!nrst)
    loopClosed |-> !robustSignallingEnable;
  endproperty
  a_robustOff: assert property (p_robustOff)
    else $error("robust signalling enabled while closed");

  property p_halfRefresh;
    @(posedge clk) disable iff (!nrst)
    take && !deact && s_q.chan == CH_AHALF && dl.rxType == RX_REFRESH && !dl.badFrameFlag
      |=> ul.valid && ul.data == '0 && !dlReady ##1 ul.valid && dlReady;
  endproperty
  a_halfRefresh: assert property (p_halfRefresh)
    else $error("half rate refresh pair wrong");

  property p_fill;
    @(posedge clk) disable iff (!nrst)
    take && !deact && adaptive && dl.rxType == RX_PAYLOAD && !dl.badFrameFlag
      |=> ul.data[259:35] == '0 && ul.data[34:0] == $past(dl.data[34:0]);
  endproperty
  a_fill: assert property (p_fill)
    else $error("robust payload placement wrong");

  property p_goodClass;
    @(posedge clk) disable iff (!nrst)
    ul.valid && adaptive |-> ul.goodClass;
  endproperty
  a_goodClass: assert property (p_goodClass)
    else $error("adaptive uplink frame not good class");

  property p_onsetZero;
    @(posedge clk) disable iff (!nrst)
    take && !deact && dl.rxType == RX_ONSET |=> ul.valid && ul.data == '0;
  endproperty
  a_onsetZero: assert property (p_onsetZero)
    else $error("onset frame not zeroed");

  property p_refreshFill;
    @(posedge clk) disable iff (!nrst)
    take && !deact && !halfAdp && dl.rxType == RX_REFRESH && !dl.badFrameFlag
      |=> ul.data[259:35] == '0 && ul.data[34:0] == $past(dl.data[34:0]);
  endproperty
  a_refreshFill: assert property (p_refreshFill)
    else $error("noise refresh placement wrong");

  property p_erasedRobust;
    @(posedge clk) disable iff (!nrst)
    take && !deact && s_q.chan == CH_AHALF && dl.rxType == RX_ROBUST && dl.badFrameFlag
      |=> ul.valid && ul.data == '0 ##1 ul.valid && ul.data == '0;
  endproperty
  a_erasedRobust: assert property (p_erasedRobust)
    else $error("erased robust frame not two zero frames");

  property p_adaptWidth;
    @(posedge clk) disable iff (!nrst)
    take && !deact && adaptive && (dl.rxType == RX_SPEECH || dl.rxType == RX_ONSET)
      |=> ul.width == $past(dl.width);
  endproperty
  a_adaptWidth: assert property (p_adaptWidth)
    else $error("adaptive width differs from decoded width");

  property p_reuseMode;
    @(posedge clk) disable iff (!nrst)
    take && !deact && adaptive && dl.rxType inside {RX_NODATA, RX_START, RX_REFRESH, RX_ROBUST}
      |=> ul.modeInd == $past(s_q.prevMode);
  endproperty
  a_reuseMode: assert property (p_reuseMode)
    else $error("mode of previous uplink frame not reused");

  property p_fixedWidth;
    @(posedge clk) disable iff (!nrst)
    take && !deact && s_q.chan == CH_ENH |=> ul.width == `EFR_BITS;
  endproperty
  a_fixedWidth: assert property (p_fixedWidth)
    else $error("enhanced full rate width wrong");

  property p_bitsPass;
    @(posedge clk) disable iff (!nrst)
    take && !deact && s_q.chan == CH_FULL && dl.rxType == RX_SPEECH |=> ul.data == $past(dl.data);
  endproperty
  a_bitsPass: assert property (p_bitsPass)
    else $error("full rate voice bits not passed");

  property p_modeMulti;
    @(posedge clk) disable iff (!nrst)
    take && !deact && adaptive && s_q.acsCount > 3'h1 && dl.rxType == RX_SPEECH
      |=> ul.modeInd == $past(dl.mode);
  endproperty
  a_modeMulti: assert property (p_modeMulti)
    else $error("uplink mode differs from decoded mode");
endmodule
`default_nettype wire

// File: sim/test_sim_partner.sv
// test system simulator model: loop close orders and guard timer
`timescale 1ns/100ps
`default_nettype none
`include "loopback_cfg.svh"
module test_sim_partner
  import loopback_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      nrst,
  input  wire logic      sendOrder,
  input  wire chanKind_t sendChan,
  input  wire logic      confirm,
  output var order_t     order,
  output logic           guardRun
);
  // ----
  // order path and guard timer
  // ----
  always_ff @(posedge clk) begin
    if (!nrst) begin
      order <= '0;
      guardRun <= 1'b0;
    end else begin
      order.valid <= sendOrder;
      order.chan <= sendOrder ? sendChan : chanKind_t'(~order.chan);
      order.link_service_point <= `CTL_LINK_SERVICE_POINT;
      order.ackMode <= 1'b1;
      if (sendOrder) begin
        guardRun <= 1'b1;
      end else if (confirm) begin
        guardRun <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/voice_channel_test_loopback_tb.sv
// self-checking bench of the traffic channel loopback
`timescale 1ns/100ps
`default_nettype none
`include "loopback_cfg.svh"
`define CHK(nm, ex, gt) begin nCompared++; if ((gt) !== (ex)) begin \
  $display("wrong value %s exp %0h got %0h", nm, ex, gt); badCount++; end end
module voice_channel_test_loopback_tb
  import loopback_pkg::*;
;
  typedef struct packed {
    chanKind_t c; rxType_t rx; logic b; logic [1:0] m; logic [8:0] w; logic [1:0] k; logic r;
  } row_t;
  localparam logic [259:0] PAT = {65{4'h9}};
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic        openOrder = 0, powerOff = 0, modRemoved = 0, trafficActive = 0;
  logic        modeCmdValid = 0, sendOrder = 0, dlReady, confirm, closed, audio, robEn, guardRun;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0]  modeCmd = '0, lastMode, em;
  logic [8:0]  lastW, ew;
  chanKind_t   sendChan = CH_FULL;
  order_t      order;
  dlFrame_t    dl = '0;
  ulFrame_t    ul;
  int          badCount = 0, nCompared = 0, cyc = 0;
  row_t rows [13] = '{
    '{CH_FULL, RX_SPEECH, 1'b0, 2'h1, 9'h0, 2'h0, 1'b0},
    '{CH_ENH, RX_SPEECH, 1'b0, 2'h1, 9'h0, 2'h0, 1'b0},
    '{CH_HALF, RX_USER, 1'b0, 2'h1, 9'h0, 2'h0, 1'b0},
    '{CH_HALF, RX_BAD, 1'b1, 2'h1, 9'h0, 2'h1, 1'b0},
    '{CH_AFULL, RX_SPEECH, 1'b0, 2'h2, 9'h09F, 2'h0, 1'b0},
    '{CH_AFULL, RX_REFRESH, 1'b0, 2'h3, 9'h027, 2'h2, 1'b1},
    '{CH_AFULL, RX_ONSET, 1'b0, 2'h1, 9'h05F, 2'h1, 1'b0},
    '{CH_AFULL, RX_NODATA, 1'b0, 2'h0, 9'h0, 2'h1, 1'b1},
    '{CH_AFULL, RX_ROBUST, 1'b0, 2'h3, 9'h027, 2'h2, 1'b1},
    '{CH_AFULL, RX_START, 1'b0, 2'h2, 9'h0, 2'h1, 1'b1},
    '{CH_AFULL, RX_BAD, 1'b1, 2'h3, 9'h0CC, 2'h1, 1'b0},
    '{CH_WFULL, RX_SPEECH, 1'b0, 2'h1, 9'h084, 2'h0, 1'b0},
    '{CH_WFULL, RX_REFRESH, 1'b1, 2'h2, 9'h027, 2'h1, 1'b1}};

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      badCount++;
      testDone();
    end
  end

  voice_loopback dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .order, .openOrder, .powerOff, .moduleRemovedPin(modRemoved), .trafficActive,
    .modeCmdValid, .modeCmd, .dl, .dlReady, .ul, .loopCloseConfirm(confirm),
    .loopClosed(closed), .audioTestActive(audio), .robustSignallingEnable(robEn));
  test_sim_partner sim (.clk, .nrst, .sendOrder, .sendChan, .confirm, .order, .guardRun);

  // ----
  // bus, order and frame tasks
  // ----
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic closeLoop(input chanKind_t c, input logic ok);
    @(posedge clk);
    {sendOrder, sendChan} <= {1'b1, c};
    @(posedge clk);
    sendOrder <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    `CHK("confirm", ok, confirm)
  endtask
  task automatic kill(input logic [2:0] v);
    @(posedge clk);
    {openOrder, powerOff, modRemoved} <= v;
    repeat (4) @(posedge clk);
    {openOrder, powerOff, modRemoved} <= 3'b000;
    @(negedge clk);
    `CHK("closed", 1'b0, closed)
    repeat (3) @(posedge clk);
  endtask
  task automatic frame(input rxType_t rx, input logic b, input logic [1:0] m, input logic [8:0] w);
    @(posedge clk);
    dl <= '{1'b1, rx, b, m, w, PAT};
    @(posedge clk);
    dl.valid <= 1'b0;
    dl.data <= ~PAT;
    @(negedge clk);
  endtask
  function automatic logic [259:0] expd(input logic [1:0] k, input logic [8:0] w);
    return (k == 0) ? PAT & ~({260{1'b1}} << w) : (k == 2) ? {225'h0, PAT[34:0]} : '0;
  endfunction
  task automatic chkUl(input logic [259:0] d, input logic [8:0] w, input logic [1:0] m,
                       input logic ad);
    `CHK("ulValid", 1'b1, ul.valid)
    `CHK("ulData", d, ul.data)
    `CHK("ulWidth", w, ul.width)
    `CHK("goodClass", 1'b1, ul.goodClass)
    if (ad) begin
      `CHK("modeInd", m, ul.modeInd)
      `CHK("modeReq", m, ul.modeReq)
    end
  endtask
  task automatic testDone();
    $display("compared %0d wrong %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, `OFF_STATUS, '0);
    `CHK("status", 32'h0000_0080, rd)
    apb(1'b0, `OFF_CTRL, '0);
    `CHK("ctrl", 32'h0000_0004, rd)
    apb(1'b0, 12'h010, '0);
    `CHK("slverr", 1'b1, err)
    apb(1'b1, `OFF_CTRL, 32'h0000_000A);
    closeLoop(CH_AFULL, 1'b0);
    @(posedge clk);
    trafficActive <= 1'b1;
    closeLoop(CH_AFULL, 1'b0);
    `CHK("audio", 1'b1, audio)
    apb(1'b1, `OFF_CTRL, 32'h0000_0008);
    @(posedge clk);
    {modeCmdValid, modeCmd} <= 3'b100;
    @(posedge clk);
    modeCmdValid <= 1'b0;
    foreach (rows[i]) begin
      if (i == 0 || rows[i].c != rows[i-1].c) begin
        if (i != 0) kill(3'b100);
        closeLoop(rows[i].c, 1'b1);
      end
      case (rows[i].c)
        CH_FULL: ew = `FR_BITS;
        CH_ENH:  ew = `EFR_BITS;
        CH_HALF: ew = `HR_BITS;
        default: ew = rows[i].r ? lastW : rows[i].w;
      endcase
      em = rows[i].r ? lastMode : rows[i].m;
      frame(rows[i].rx, rows[i].b, rows[i].m, rows[i].w);
      chkUl(expd(rows[i].k, ew), ew, em, rows[i].c >= CH_AFULL);
      {lastW, lastMode} = {ew, em};
    end
    closeLoop(CH_FULL, 1'b0);
    apb(1'b1, `OFF_CTRL, 32'h0000_000A);
    apb(1'b0, `OFF_STATUS, '0);
    `CHK("status", {24'h0, 1'b0, lastMode, CH_WFULL, 2'b01}, rd)
    kill(3'b100);
    closeLoop(CH_AHALF, 1'b1);
    frame(RX_SPEECH, 1'b0, 2'h1, 9'h050);
    chkUl(expd(2'h0, 9'h050), 9'h050, 2'h1, 1'b1);
    frame(RX_REFRESH, 1'b0, 2'h2, 9'h027);
    chkUl('0, 9'h050, 2'h1, 1'b1);
    `CHK("dlReady", 1'b0, dlReady)
    @(negedge clk);
    chkUl(expd(2'h2, 9'h0), 9'h050, 2'h1, 1'b1);
    frame(RX_ROBUST, 1'b1, 2'h3, 9'h027);
    chkUl('0, 9'h050, 2'h1, 1'b1);
    @(negedge clk);
    chkUl('0, 9'h050, 2'h1, 1'b1);
    frame(RX_MARKER, 1'b0, 2'h3, 9'h027);
    chkUl('0, 9'h050, 2'h1, 1'b1);
    frame(RX_PAYLOAD, 1'b0, 2'h3, 9'h027);
    chkUl(expd(2'h2, 9'h0), 9'h050, 2'h1, 1'b1);
    kill(3'b010);
    closeLoop(CH_AHALF, 1'b1);
    kill(3'b001);
    // ----
    // reset in mid-run, then a single-mode codec set
    // ----
    closeLoop(CH_FULL, 1'b1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK("closed", 1'b0, closed)
    `CHK("robEn", 1'b1, robEn)
    `CHK("dlReady", 1'b1, dlReady)
    apb(1'b0, `OFF_CTRL, '0);
    `CHK("ctrl", 32'h0000_0004, rd)
    @(posedge clk);
    {modeCmdValid, modeCmd} <= 3'b111;
    @(posedge clk);
    modeCmdValid <= 1'b0;
    closeLoop(CH_AFULL, 1'b1);
    frame(RX_SPEECH, 1'b0, 2'h1, 9'h050);
    chkUl(expd(2'h0, 9'h050), 9'h050, 2'h3, 1'b1);
    testDone();
  end
endmodule
`default_nettype wire
